// ---- rtl/pmlb_defs.svh ----
// Constants for the macrocell logic array block
`ifndef PMLB_DEFS_SVH
`define PMLB_DEFS_SVH
`define PMLB_NUM_MC 16
`define PMLB_NUM_PT 5
`define PMLB_NUM_DED 4
`define PMLB_GBUS_W 36
`define PMLB_PTIN_W 52
`define PMLB_NUM_GNET 2
`define PMLB_NUM_GOE 6
`define PMLB_CHAIN_LEN 8
`define PMLB_NUM_SETS 3
`define PMLB_SHX_PT 4
`define PMLB_MEM_WORDS 512
`define PMLB_MEM_AW 9
`define PMLB_MC_STRIDE 32
`define PMLB_PT_STRIDE 4
`define PMLB_CFG_WORD 24
`define PMLB_MASK_HI_W 20
`define PMLB_DED_CLK_ONE 0
`define PMLB_DED_CLK_TWO 1
`define PMLB_DED_OE_ONE 2
`define PMLB_DED_CLR 3
`define PMLB_OFS_CTRL 12'h800
`define PMLB_OFS_GNET 12'h804
`define PMLB_OFS_GOE 12'h808
`define PMLB_OFS_IOE_LO 12'h80C
`define PMLB_OFS_IOE_HI 12'h810
`define PMLB_OFS_STAT 12'h814
`define PMLB_CTRL_PWRUP_BIT 0
`define PMLB_RST_SYNC 20'h00008
`define PMLB_RST_GNET 4'h4
`define PMLB_RST_GOE 18'h00000
`define PMLB_RST_IOE 32'h6666_6666
`define PMLB_IOE_MASK 32'h7777_7777
`define PMLB_IOE_GND 3'h6
`define PMLB_IOE_VCC 3'h7
`define PMLB_PT_NONE 3'h5
`endif

// ---- rtl/pmlb_pkg.sv ----
// Types shared by the macrocell logic array block
`include "pmlb_defs.svh"
package pmlb_pkg;
  typedef enum logic [1:0] {PMLB_FF_D, PMLB_FF_T, PMLB_FF_JK, PMLB_FF_SR} pmlb_ff_t;
  typedef enum logic [1:0] {PMLB_CK_GLOBAL, PMLB_CK_GATED, PMLB_CK_ARRAY} pmlb_ck_t;
  typedef enum logic [1:0] {PMLB_APB_IDLE, PMLB_APB_WAIT, PMLB_APB_DONE} pmlb_apb_st_t;
  typedef logic [`PMLB_NUM_PT-1:0] pmlb_pt_t;
  typedef struct packed {
    logic       rsvd;
    logic [1:0] borrow_sets;
    logic       lend_en;
    logic       shx_en;
    logic       xor_inv;
    logic       pwrup;
    logic       gclr_en;
    logic       fast_in;
    logic       bypass;
    logic       gnet;
    pmlb_ck_t   clk_mode;
    pmlb_ff_t   ff_type;
    logic [2:0] kr_sel;
    logic [2:0] clk_sel;
    logic [2:0] clr_sel;
    logic [2:0] pre_sel;
    pmlb_pt_t   prim_mask;
  } pmlb_mc_cfg_t;
  typedef struct packed {
    logic pre;
    logic clr;
    logic clk;
    logic kr;
  } pmlb_ctl_t;
endpackage

// ---- rtl/pmlb_cfg_mem.sv ----
// Configuration store: parallel contents plus registered read port
`include "pmlb_defs.svh"
module pmlb_cfg_mem
  import pmlb_pkg::*;
(
  input  wire logic                    clk_sys,
  input  wire logic                    rst_b,
  input  wire logic                    wr_en,
  input  wire logic [`PMLB_MEM_AW-1:0] wr_addr,
  input  wire logic [31:0]             wr_data,
  input  wire logic                    rd_en,
  input  wire logic [`PMLB_MEM_AW-1:0] rd_addr,
  output logic      [31:0]             rd_data,
  output wire logic [31:0]             all_q [`PMLB_MEM_WORDS]
);
  for (genvar w = 0; w < `PMLB_MEM_WORDS; w++) begin : g_word
    logic [31:0] word_r;
    always_ff @(posedge clk_sys or negedge rst_b) begin
      if (!rst_b) begin
        word_r <= 32'h0000_0000;
      end else if (wr_en && (wr_addr == `PMLB_MEM_AW'(w))) begin
        word_r <= wr_data;
      end
    end
    assign all_q[w] = word_r;
  end

  always_ff @(posedge clk_sys or negedge rst_b) begin
    if (!rst_b) begin
      rd_data <= 32'h0000_0000;
    end else if (rd_en) begin
      rd_data <= all_q[rd_addr];
    end
  end
endmodule

// ---- rtl/pmlb_mc_reg.sv ----
// Programmable macrocell register
`include "pmlb_defs.svh"
module pmlb_mc_reg
  import pmlb_pkg::*;
(
  input  wire logic         clk_sys,
  input  wire logic         rst_b,
  input  pmlb_mc_cfg_t      cfg,
  input  pmlb_ctl_t         ctl,
  input  wire logic         sum,
  input  wire logic         fast_d,
  input  wire logic [1:0]   gedge,
  input  wire logic         global_clear_pin_low_b,
  input  wire logic         pwrup_load,
  output logic              q
);
  logic aclk_prev_r;
  logic capture;
  logic d_in;
  logic next_q;
  logic clr_any;

  assign clr_any = ctl.clr | (cfg.gclr_en & ~global_clear_pin_low_b); // R11 R12

  always_ff @(posedge clk_sys or negedge rst_b) begin
    if (!rst_b) begin
      aclk_prev_r <= 1'b0;
    end else begin
      aclk_prev_r <= ctl.clk;
    end
  end

  always_comb begin
    capture = 1'b0;
    unique case (cfg.clk_mode)
      PMLB_CK_GLOBAL: capture = gedge[cfg.gnet]; // R8
      PMLB_CK_GATED:  capture = gedge[cfg.gnet] & ctl.clk; // R9
      PMLB_CK_ARRAY:  capture = ctl.clk & ~aclk_prev_r; // R8
      default:        capture = 1'b0;
    endcase
    d_in = cfg.fast_in ? fast_d : sum; // R14
    unique case (cfg.ff_type)
      PMLB_FF_D:  next_q = d_in; // R6
      PMLB_FF_T:  next_q = q ^ d_in;
      PMLB_FF_JK: next_q = (d_in & ~q) | (~ctl.kr & q);
      PMLB_FF_SR: next_q = d_in | (q & ~ctl.kr);
    endcase
  end

  // Clear beats preset; bypass follows the logic sum every cycle
  always_ff @(posedge clk_sys or negedge rst_b) begin
    if (!rst_b) begin
      q <= 1'b0;
    end else if (cfg.bypass) begin
      q <= sum; // R7
    end else if (clr_any) begin
      q <= 1'b0; // R11 R12
    end else if (ctl.pre) begin
      q <= 1'b1; // R11
    end else if (pwrup_load) begin
      q <= cfg.pwrup; // R13
    end else if (capture) begin
      q <= next_q;
    end
  end

  default clocking @(posedge clk_sys); endclocking
  default disable iff (!rst_b);

  property p_bypass;
    cfg.bypass |=> (q == $past(sum));
  endproperty
  a_bypass: assert property (p_bypass) else $error("bypass output wrong"); // R7
  property p_gclr;
    (!cfg.bypass && cfg.gclr_en && !global_clear_pin_low_b) |=> !q;
  endproperty
  a_gclr: assert property (p_gclr) else $error("global clear missed"); // R12
  property p_pre;
    (!cfg.bypass && !clr_any && ctl.pre) |=> q;
  endproperty
  a_pre: assert property (p_pre) else $error("preset missed"); // R11
  property p_gated_hold;
    (!cfg.bypass && cfg.clk_mode == PMLB_CK_GATED && !ctl.clk && !clr_any && !ctl.pre
     && !pwrup_load) |=> $stable(q);
  endproperty
  a_gated_hold: assert property (p_gated_hold) else $error("gated register moved"); // R9
  property p_array_d;
    (!cfg.bypass && cfg.clk_mode == PMLB_CK_ARRAY && cfg.ff_type == PMLB_FF_D && !clr_any
     && !ctl.pre && !pwrup_load && ctl.clk && !$past(ctl.clk)) |=> (q == $past(d_in));
  endproperty
  a_array_d: assert property (p_array_d) else $error("array clock capture wrong"); // R8
  property p_pwrup;
    (!cfg.bypass && !clr_any && !ctl.pre && pwrup_load) |=> (q == $past(cfg.pwrup));
  endproperty
  a_pwrup: assert property (p_pwrup) else $error("power-up value wrong"); // R13
endmodule

// ---- rtl/pmlb_lab.sv ----
// Logic array block: sixteen macrocells, expanders, routing and APB config
//
// Functional notes
// R1: each block holds exactly sixteen macrocells
// R2: block takes 36 routing-bus signals as inputs
// R3: routing bus carries dedicated, pin, macrocell signals
// R4: five product terms dedicated to each macrocell
// R5: terms feed OR/XOR or register controls
// R6: register acts as D, T, JK, SR
// R7: bypass gives purely combinational macrocell output; code registers the logic sum each clk_sys cycle
// R8: global, gated global, or array clock
// R9: gated mode captures only with enable high
// R10: two global clocks, true/inverted, either pin
// R11: term preset and clear, active high
// R12: per-register response to low global clear
// R13: configured power-up value per register
// R14: pin has direct path to register input
// R15: sixteen inverted shared expanders, one per macrocell
// R16: borrow unused terms from adjacent macrocells
// R17: up to 32 terms per macrocell; code allows at most 20, five own plus three borrowed sets of five
// R18: four dedicated inputs, general or global control
// R19: six global output enables drive pins
// R20: up to three sets of five borrowed
// R21: two chains of eight, borrow from lower
// R22: configuration held static during operation
//
// The placing of the registers and register access over APB were left to the implementer.
`include "pmlb_defs.svh"
module pmlb_lab
  import pmlb_pkg::*;
(
  input  wire logic                     clk_sys,
  input  wire logic                     rst_b,
  input  wire logic [`PMLB_NUM_DED-1:0] ded_in,
  input  wire logic [`PMLB_NUM_MC-1:0]  io_in,
  output logic      [`PMLB_NUM_MC-1:0]  io_out,
  output logic      [`PMLB_NUM_MC-1:0]  io_oe,
  input  wire logic                     psel,
  input  wire logic                     penable,
  input  wire logic                     pwrite,
  input  wire logic [11:0]              paddr,
  input  wire logic [31:0]              pwdata,
  output logic      [31:0]              prdata,
  output logic                          pready,
  output logic                          pslverr
);
  localparam int NSYNC = `PMLB_NUM_MC + `PMLB_NUM_DED;

  logic [NSYNC-1:0]               meta_r;
  logic [NSYNC-1:0]               sync_r;
  logic [`PMLB_NUM_DED-1:0]       ded_s;
  logic [`PMLB_NUM_MC-1:0]        io_s;
  logic [`PMLB_GBUS_W-1:0]        gbus;
  logic [`PMLB_PTIN_W-1:0]        xin;
  wire  [`PMLB_NUM_MC-1:0]        mc_q;
  wire  [`PMLB_NUM_MC-1:0]        shx;
  wire  [`PMLB_NUM_MC-1:0]        lend;
  wire  [`PMLB_NUM_SETS-1:0]      brw [`PMLB_NUM_MC];
  wire  [`PMLB_NUM_PT-1:0]        pt [`PMLB_NUM_MC];
  wire  [`PMLB_NUM_GNET-1:0]      gnet;
  wire  [`PMLB_NUM_GOE-1:0]       goe;
  wire  [`PMLB_NUM_MC-1:0]        oe_nxt;
  logic [`PMLB_NUM_GNET-1:0]      gnet_prev_r;
  logic [`PMLB_NUM_GNET-1:0]      gedge;
  logic [3:0]                     gnet_r;
  logic [17:0]                    goe_r;
  logic [63:0]                    ioe_r;
  logic                           pwrup_load_r;
  wire  logic [31:0]              cfg_q [`PMLB_MEM_WORDS];
  logic [31:0]                    mem_rd;
  pmlb_apb_st_t                   apb_st_r;
  logic                           err_r;
  logic                           addr_ok;
  logic                           in_mem;
  logic                           wr_fire;
  logic                           rd_start;
  logic [31:0]                    rd_glob;
  logic [`PMLB_NUM_MC-1:0]        io_out_r;
  logic [`PMLB_NUM_MC-1:0]        io_oe_r;
  logic [31:0]                    prdata_r;
  logic                           pready_r;
  logic                           pslverr_r;

  function automatic logic pick(input pmlb_pt_t p, input logic [2:0] s);
    pick = (s < `PMLB_PT_NONE) ? p[s] : 1'b0;
  endfunction

  ////////////////////////////////////////////////////////////////////////////////////////////
  // Pin synchronisers and the global routing bus
  always_ff @(posedge clk_sys or negedge rst_b) begin
    if (!rst_b) begin
      meta_r <= `PMLB_RST_SYNC;
      sync_r <= `PMLB_RST_SYNC;
    end else begin
      meta_r <= {io_in, ded_in};
      sync_r <= meta_r;
    end
  end

  assign ded_s = sync_r[`PMLB_NUM_DED-1:0];
  assign io_s  = sync_r[NSYNC-1:`PMLB_NUM_DED];
  // Dedicated inputs also serve as general logic inputs
  assign gbus  = {mc_q, io_s, ded_s}; // R2 R3 R18
  assign xin   = {shx, gbus}; // R15

  ////////////////////////////////////////////////////////////////////////////////////////////
  // Global clock networks
  for (genvar n = 0; n < `PMLB_NUM_GNET; n++) begin : g_gnet
    logic [1:0] f;
    assign f = gnet_r[2*n +: 2];
    assign gnet[n] = (f[0] ? ded_s[`PMLB_DED_CLK_TWO] : ded_s[`PMLB_DED_CLK_ONE]) ^ f[1]; // R10
  end

  always_ff @(posedge clk_sys or negedge rst_b) begin
    if (!rst_b) begin
      gnet_prev_r <= '0;
    end else begin
      gnet_prev_r <= gnet;
    end
  end

  assign gedge = gnet & ~gnet_prev_r; // R10

  ////////////////////////////////////////////////////////////////////////////////////////////
  // Macrocells: product terms, expanders, select matrix, register
  for (genvar i = 0; i < `PMLB_NUM_MC; i++) begin : g_mc // R1
    localparam int CBASE = i * `PMLB_MC_STRIDE;
    localparam int POS   = i % `PMLB_CHAIN_LEN;
    pmlb_mc_cfg_t cfg;
    pmlb_pt_t     shx_m;
    pmlb_pt_t     prim;
    pmlb_ctl_t    ctl;
    logic         sum;

    // Configuration words only change by software between uses
    assign cfg = pmlb_mc_cfg_t'(cfg_q[CBASE + `PMLB_CFG_WORD]); // R22

    for (genvar t = 0; t < `PMLB_NUM_PT; t++) begin : g_pt
      localparam int TB = CBASE + t * `PMLB_PT_STRIDE;
      logic [`PMLB_PTIN_W-1:0] m_t;
      logic [`PMLB_PTIN_W-1:0] m_c;
      assign m_t = {cfg_q[TB+1][`PMLB_MASK_HI_W-1:0], cfg_q[TB]};
      assign m_c = {cfg_q[TB+3][`PMLB_MASK_HI_W-1:0], cfg_q[TB+2]};
      assign pt[i][t] = &(~m_t | xin) & &(~m_c | ~xin); // R4
      if (t == `PMLB_SHX_PT) begin : g_shx
        // Expander term sees only the routing bus, so no feedback loop
        assign shx[i] = ~(&(~m_t[`PMLB_GBUS_W-1:0] | gbus)
                        & &(~m_c[`PMLB_GBUS_W-1:0] | ~gbus)); // R15
      end
    end

    assign shx_m = {cfg.shx_en, 4'h0};
    assign prim  = pt[i] & cfg.prim_mask & ~shx_m; // R5

    if (POS == `PMLB_CHAIN_LEN - 1) begin : g_top
      assign lend[i] = 1'b0; // R21
    end else begin : g_lend
      assign lend[i] = cfg.lend_en & |(pt[i] & ~cfg.prim_mask & ~shx_m); // R16
    end

    for (genvar k = 1; k <= `PMLB_NUM_SETS; k++) begin : g_brw
      if (POS >= k) begin : g_on
        assign brw[i][k-1] = (cfg.borrow_sets >= 2'(k)) & lend[i-k]; // R16 R20
      end else begin : g_off
        assign brw[i][k-1] = 1'b0; // R21
      end
    end

    // Local and borrowed terms meet in the OR, then the XOR; shared expanders enter only as term inputs
    assign sum = (|prim | |brw[i]) ^ cfg.xor_inv; // R5 R17

    assign ctl.pre = pick(pt[i], cfg.pre_sel); // R5 R11
    assign ctl.clr = pick(pt[i], cfg.clr_sel); // R5 R11
    assign ctl.clk = pick(pt[i], cfg.clk_sel); // R5 R8
    assign ctl.kr  = pick(pt[i], cfg.kr_sel);

    pmlb_mc_reg u_reg (
      .clk_sys                (clk_sys),
      .rst_b                  (rst_b),
      .cfg                    (cfg),
      .ctl                    (ctl),
      .sum                    (sum),
      .fast_d                 (io_s[i]),
      .gedge                  (gedge),
      .global_clear_pin_low_b (ded_s[`PMLB_DED_CLR]),
      .pwrup_load             (pwrup_load_r),
      .q                      (mc_q[i])
    ); // R14 R12
  end

  ////////////////////////////////////////////////////////////////////////////////////////////
  // Global output enables and pin drivers
  for (genvar k = 0; k < `PMLB_NUM_GOE; k++) begin : g_goe
    logic [2:0] f;
    assign f = goe_r[3*k +: 3];
    assign goe[k] = f[2] ^ (f[1] ? (f[0] ? io_s[k] : mc_q[k])
                           : (f[0] ? ded_s[`PMLB_DED_CLK_TWO] : ded_s[`PMLB_DED_OE_ONE])); // R19
  end

  for (genvar p = 0; p < `PMLB_NUM_MC; p++) begin : g_ioe
    logic [2:0] sel;
    assign sel = ioe_r[4*p +: 3];
    assign oe_nxt[p] = (sel < `PMLB_IOE_GND) ? goe[sel] : (sel == `PMLB_IOE_VCC); // R19
  end

  always_ff @(posedge clk_sys or negedge rst_b) begin
    if (!rst_b) begin
      io_out_r <= '0;
      io_oe_r  <= '0;
    end else begin
      io_out_r <= mc_q;
      io_oe_r  <= oe_nxt;
    end
  end

  assign io_out = io_out_r;
  assign io_oe  = io_oe_r;

  ////////////////////////////////////////////////////////////////////////////////////////////
  // APB slave
  assign in_mem   = ~paddr[11];
  assign rd_start = (apb_st_r == PMLB_APB_IDLE) && psel && !penable;
  assign wr_fire  = (apb_st_r == PMLB_APB_DONE) && psel && penable && pwrite && !err_r;

  always_comb begin
    addr_ok = (paddr[1:0] == 2'h0);
    rd_glob = 32'h0000_0000;
    if (!in_mem) begin
      case (paddr)
        `PMLB_OFS_CTRL:   rd_glob = 32'h0000_0000;
        `PMLB_OFS_GNET:   rd_glob = {28'h0000000, gnet_r};
        `PMLB_OFS_GOE:    rd_glob = {14'h0000, goe_r};
        `PMLB_OFS_IOE_LO: rd_glob = ioe_r[31:0];
        `PMLB_OFS_IOE_HI: rd_glob = ioe_r[63:32];
        `PMLB_OFS_STAT:   rd_glob = {12'h000, ded_s, mc_q};
        default:          addr_ok = 1'b0;
      endcase
    end
  end

  always_ff @(posedge clk_sys or negedge rst_b) begin
    if (!rst_b) begin
      apb_st_r  <= PMLB_APB_IDLE;
      err_r     <= 1'b0;
      prdata_r  <= 32'h0000_0000;
      pready_r  <= 1'b0;
      pslverr_r <= 1'b0;
    end else begin
      unique case (apb_st_r)
        PMLB_APB_IDLE: begin
          pready_r  <= 1'b0;
          pslverr_r <= 1'b0;
          if (rd_start) begin
            apb_st_r <= PMLB_APB_WAIT;
            err_r    <= ~addr_ok;
          end
        end
        PMLB_APB_WAIT: begin
          apb_st_r  <= PMLB_APB_DONE;
          pready_r  <= 1'b1;
          pslverr_r <= err_r;
          prdata_r  <= (err_r || pwrite) ? 32'h0000_0000 : (in_mem ? mem_rd : rd_glob);
        end
        PMLB_APB_DONE: begin
          apb_st_r  <= PMLB_APB_IDLE;
          pready_r  <= 1'b0;
          pslverr_r <= 1'b0;
          prdata_r  <= 32'h0000_0000;
        end
        default: apb_st_r <= PMLB_APB_IDLE;
      endcase
    end
  end

  assign prdata  = prdata_r;
  assign pready  = pready_r;
  assign pslverr = pslverr_r;

  pmlb_cfg_mem u_cfg (
    .clk_sys (clk_sys),
    .rst_b   (rst_b),
    .wr_en   (wr_fire && in_mem),
    .wr_addr (paddr[10:2]),
    .wr_data (pwdata),
    .rd_en   (rd_start && in_mem),
    .rd_addr (paddr[10:2]),
    .rd_data (mem_rd),
    .all_q   (cfg_q)
  );

  ////////////////////////////////////////////////////////////////////////////////////////////
  // Global registers
  always_ff @(posedge clk_sys or negedge rst_b) begin
    if (!rst_b) begin
      gnet_r <= `PMLB_RST_GNET;
      goe_r  <= `PMLB_RST_GOE;
      ioe_r  <= {`PMLB_RST_IOE, `PMLB_RST_IOE};
    end else if (wr_fire) begin
      case (paddr)
        `PMLB_OFS_GNET:   gnet_r <= pwdata[3:0];
        `PMLB_OFS_GOE:    goe_r <= pwdata[17:0];
        `PMLB_OFS_IOE_LO: ioe_r[31:0] <= pwdata & `PMLB_IOE_MASK;
        `PMLB_OFS_IOE_HI: ioe_r[63:32] <= pwdata & `PMLB_IOE_MASK;
        default:          ;
      endcase
    end
  end

  // Power-up values load after reset and on software request
  always_ff @(posedge clk_sys or negedge rst_b) begin
    if (!rst_b) begin
      pwrup_load_r <= 1'b1;
    end else begin
      pwrup_load_r <= wr_fire && (paddr == `PMLB_OFS_CTRL) && pwdata[`PMLB_CTRL_PWRUP_BIT]; // R13
    end
  end

  ////////////////////////////////////////////////////////////////////////////////////////////
  // Checks
  default clocking @(posedge clk_sys); endclocking
  default disable iff (!rst_b);

  property p_oe_gnd;
    (ioe_r[2:0] == `PMLB_IOE_GND) |=> !io_oe[0];
  endproperty
  a_oe_gnd: assert property (p_oe_gnd) else $error("pin 0 driven while grounded"); // R19
  property p_oe_goe;
    (ioe_r[2:0] == 3'h0) |=> (io_oe[0] == $past(goe[0]));
  endproperty
  a_oe_goe: assert property (p_oe_goe) else $error("pin 0 enable not from goe 0"); // R19
  property p_chain_ends;
    (brw[0] == 3'h0) && (brw[8] == 3'h0) && !lend[7] && !lend[15];
  endproperty
  a_chain_ends: assert property (p_chain_ends) else $error("chain end lends or borrows"); // R21
  property p_apb_wait;
    rd_start |=> !pready ##1 (pready && apb_st_r == PMLB_APB_DONE);
  endproperty
  a_apb_wait: assert property (p_apb_wait) else $error("apb answer timing wrong");

  c_write:  cover property (wr_fire && in_mem);
  c_gedge:  cover property (gedge[0] ##1 gedge[1]);
  c_err:    cover property (pready && pslverr);
  c_borrow: cover property (|brw[1]);
endmodule

// ---- test/pmlb_lab_tb.sv ----
// Self-checking bench for the macrocell logic array block
`include "pmlb_defs.svh"
module pmlb_lab_tb
  import pmlb_pkg::*;
;
  timeunit 1ns;
  timeprecision 1ps;

  ////////////////////////////////////////////////////////////////////////////
  logic        clk_sys;
  logic        rst_b;
  logic [3:0]  ded_in;
  logic [15:0] io_in;
  logic [15:0] io_out;
  logic [15:0] io_oe;
  logic        psel;
  logic        penable;
  logic        pwrite;
  logic [11:0] paddr;
  logic [31:0] pwdata;
  logic [31:0] prdata;
  logic        pready;
  logic        pslverr;
  int          fail_count;
  int          cmp_count;
  logic        q;
  logic [1:0]  pat [6] = '{2'h1, 2'h3, 2'h1, 2'h0, 2'h2, 2'h3};
  localparam logic [31:0] F_GCLR = 32'h0100_0000;
  localparam logic [31:0] F_BYP  = 32'h0040_0000;
  localparam logic [31:0] F_FAST = 32'h0080_0000;
  localparam logic [31:0] F_PUP  = 32'h0200_0000;

  always #2.5 clk_sys = ~clk_sys;

  pmlb_lab u_pmlb_lab (
    .clk_sys(clk_sys), .rst_b(rst_b), .ded_in(ded_in), .io_in(io_in), .io_out(io_out),
    .io_oe(io_oe), .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr),
    .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr)
  );

  ////////////////////////////////////////////////////////////////////////////
  task automatic final_report();
    $display("Comparisons %0d, mismatches %0d", cmp_count, fail_count);
    if (fail_count == 0 && cmp_count > 0) begin
      $display("Finished cleanly");
    end else begin
      $display("Finished with errors");
    end
    $finish;
  endtask

  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    cmp_count++;
    if (got !== exp) begin
      fail_count++;
      $display("[ERR] %0t got %h expected %h", $time, got, exp);
    end
  endtask

  task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d,
                     output logic [31:0] r, output logic e);
    int n;
    n = 0;
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge clk_sys);
    penable <= 1'b1;
    do begin
      @(posedge clk_sys);
      n++;
    end while (pready !== 1'b1 && n < 50);
    r = prdata;
    e = pslverr;
    if (pready !== 1'b1) begin
      fail_count++;
      final_report();
    end
    psel <= 1'b0;
    penable <= 1'b0;
    @(posedge clk_sys);
  endtask

  task automatic wr(input logic [11:0] a, input logic [31:0] d);
    logic [31:0] r;
    logic        e;
    apb(1'b1, a, d, r, e);
  endtask

  task automatic rd(input logic [11:0] a, input logic [31:0] exp);
    logic [31:0] r;
    logic        e;
    apb(1'b0, a, 32'h0, r, e);
    chk(r, exp);
    chk({31'h0, e}, 32'h0);
  endtask

  task automatic err(input logic [11:0] a);
    logic [31:0] r;
    logic        e;
    apb(1'b0, a, 32'h0, r, e);
    chk(r, 32'h0);
    chk({31'h0, e}, 32'h1);
  endtask

  // Poll one macrocell state bit until it matches the expected value or the bound runs out
  task automatic sq(input logic exp, input int b = 0);
    logic [31:0] r;
    logic        e;
    int          n;
    n = 0;
    do begin
      apb(1'b0, 12'h814, 32'h0, r, e);
      n++;
    end while (r[b] !== exp && n < 20);
    chk({31'h0, r[b]}, {31'h0, exp});
    if (r[b] !== exp) begin
      final_report();
    end
  endtask

  task automatic wait_c(input int n);
    repeat (n) @(posedge clk_sys);
  endtask

  task automatic tick();
    ded_in[0] <= 1'b1;
    wait_c(6);
    ded_in[0] <= 1'b0;
    wait_c(6);
  endtask

  task automatic gclr();
    ded_in[3] <= 1'b0;
    wait_c(6);
    ded_in[3] <= 1'b1;
    wait_c(6);
  endtask

  task automatic pins(input logic [4:0] v);
    io_in <= {11'h000, v};
    wait_c(4);
  endtask

  function automatic logic [31:0] cw(input logic [2:0] pre, input logic [2:0] clr,
                                     input logic [2:0] ck, input logic [2:0] kr,
                                     input logic [1:0] ff, input logic [1:0] md,
                                     input logic [31:0] fl);
    return fl | 32'h1 | 32'(pre) << 5 | 32'(clr) << 8 | 32'(ck) << 11 | 32'(kr) << 14
           | 32'(ff) << 17 | 32'(md) << 19;
  endfunction

  // Next state: j is data/set, k is K/reset
  function automatic logic nx(input int f, input logic qo, input logic j, input logic k);
    case (f)
      0: return j;
      1: return j ^ qo;
      2: return (j & k) ? ~qo : (j ? 1'b1 : (k ? 1'b0 : qo));
      default: return j ? 1'b1 : (k ? 1'b0 : qo);
    endcase
  endfunction

  ////////////////////////////////////////////////////////////////////////////
  initial begin
    clk_sys = 1'b0;
    rst_b = 1'b0;
    ded_in = 4'h8;
    io_in = 16'h0000;
    psel = 1'b0;
    penable = 1'b0;
    pwrite = 1'b0;
    paddr = 12'h000;
    pwdata = 32'h0;
    fail_count = 0;
    cmp_count = 0;
    wait_c(12);
    rst_b <= 1'b1;
    wait_c(1);
    rd(12'h804, 32'h0000_0004);
    rd(12'h808, 32'h0000_0000);
    rd(12'h80C, 32'h6666_6666);
    rd(12'h810, 32'h6666_6666);
    chk({16'h0, io_oe}, 32'h0);
    err(12'h818);
    err(12'h802);
    wr(12'h000, 32'h10);
    wr(12'h010, 32'h20);
    wr(12'h020, 32'h40);
    wr(12'h030, 32'h80);
    wr(12'h040, 32'h100);
    wr(12'h060, cw(5, 5, 5, 5, 0, 0, F_BYP | F_GCLR));
    wr(12'h80C, 32'h6666_6667);
    pins(5'h01);
    sq(1'b1);
    wait_c(2);
    chk({16'h0, io_out & io_oe}, 32'h1);
    pins(5'h00);
    sq(1'b0);
    // Every flipflop type through one pattern
    for (int f = 0; f < 4; f++) begin
      wr(12'h060, cw(5, 5, 5, 1, f[1:0], 0, F_GCLR));
      gclr();
      q = 1'b0;
      sq(q);
      for (int s = 0; s < 6; s++) begin
        pins({3'h0, pat[s]});
        tick();
        q = nx(f, q, pat[s][0], pat[s][1]);
        sq(q);
      end
    end
    wr(12'h060, cw(5, 5, 2, 5, 0, 1, F_GCLR));
    gclr();
    pins(5'h01);
    tick();
    sq(1'b0);
    pins(5'h05);
    tick();
    sq(1'b1);
    wr(12'h060, cw(5, 5, 2, 5, 0, 2, F_GCLR));
    pins(5'h01);
    gclr();
    tick();
    sq(1'b0);
    pins(5'h05);
    sq(1'b1);
    wr(12'h060, cw(3, 4, 5, 5, 0, 3, F_GCLR));
    pins(5'h00);
    gclr();
    pins(5'h08);
    sq(1'b1);
    pins(5'h18);
    sq(1'b0);
    wr(12'h060, cw(5, 5, 5, 5, 0, 3, F_GCLR | F_PUP));
    pins(5'h00);
    gclr();
    sq(1'b0);
    wr(12'h800, 32'h1);
    sq(1'b1);
    // Pin 0 enable from global enable 0, fed by enable pin one
    wr(12'h80C, 32'h6666_6660);
    ded_in[2] <= 1'b1;
    wait_c(6);
    chk({31'h0, io_oe[0]}, 32'h1);
    wr(12'h808, 32'h4);
    wait_c(2);
    chk({31'h0, io_oe[0]}, 32'h0);
    // Inverted global net captures on the falling pin edge
    wr(12'h060, cw(5, 5, 5, 5, 0, 0, F_GCLR));
    wr(12'h804, 32'h6);
    pins(5'h01);
    gclr();
    ded_in[0] <= 1'b1;
    wait_c(6);
    sq(1'b0);
    ded_in[0] <= 1'b0;
    wait_c(6);
    sq(1'b1);
    wr(12'h804, 32'h4);
    wr(12'h000, 32'h20);
    wr(12'h060, cw(5, 5, 5, 5, 0, 0, F_FAST | F_GCLR));
    pins(5'h01);
    gclr();
    tick();
    sq(1'b1);
    pins(5'h02);
    tick();
    sq(1'b0);
    // Macrocell 1 fed by shared expander and borrowed terms of macrocell 0
    wr(12'h084, 32'h10);
    wr(12'h060, 32'h1800_0001);
    wr(12'h0E0, 32'h2040_0001);
    pins(5'h10);
    sq(1'b0, 1);
    pins(5'h00);
    sq(1'b1, 1);
    pins(5'h18);
    sq(1'b1, 1);
    wr(12'h0E0, 32'h0040_0001);
    sq(1'b0, 1);
    wr(12'h0E0, 32'h2440_0001);
    sq(1'b0, 1);
    final_report();
  end
endmodule
